/* File: design/eepc_core.sv */
`timescale 1ns/1ns
`default_nettype none
module eepc_core (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    eepc_if.core             bus,
    input  wire logic        i_cmd_valid,
    input  wire logic [1:0]  i_cmd_op,
    input  wire logic [15:0] i_cmd_addr,
    input  wire logic [7:0]  i_cmd_data,
    input  wire logic        i_irq_enable,
    output logic             o_cmd_ready,
    output logic [7:0]       o_rd_data,
    output logic             o_rd_valid,
    output logic             o_global_interrupt_enable
);

    typedef enum logic [2:0] {
        EEPC_S_IDLE    = 3'b000,
        EEPC_S_CHECK   = 3'b001,
        EEPC_S_MAP     = 3'b010,
        EEPC_S_ACCESS  = 3'b011,
        EEPC_S_WAIT    = 3'b100,
        EEPC_S_UNMAP   = 3'b101,
        EEPC_S_LAUNCH1 = 3'b110,
        EEPC_S_LAUNCH2 = 3'b111
    } eepc_state_type;

    eepc_state_type state_q, state_d;
    logic [1:0]     op_q, op_d;
    logic [15:0]    addr_q, addr_d;
    logic [7:0]     data_q, data_d;
    logic [7:0]     rd_q, rd_d;
    logic           rdv_q, rdv_d;
    logic           gie_q, gie_d;
    logic           saved_q, saved_d;

    always_comb begin
        state_d       = state_q;
        op_d          = op_q;
        addr_d        = addr_q;
        data_d        = data_q;
        rd_d          = rd_q;
        rdv_d         = 1'b0;
        gie_d         = gie_q;
        saved_d       = saved_q;
        bus.instr     = 1'b0;
        bus.ctl_we    = 1'b0;
        bus.ctl_wdata = eepc_pkg::CMD_UNMAP;
        bus.xd_req    = 1'b0;
        bus.xd_we     = 1'b0;
        case (state_q)
            EEPC_S_IDLE: begin
                gie_d = i_irq_enable;
                if (i_cmd_valid) begin
                    saved_d = i_irq_enable;
                    gie_d   = 1'b0;
                    op_d    = i_cmd_op;
                    addr_d  = i_cmd_addr;
                    data_d  = i_cmd_data;
                    state_d = EEPC_S_CHECK;
                end
            end
            EEPC_S_CHECK: begin
                if (!bus.ctl_rdata[eepc_pkg::CTL_BUSY_BIT]) begin
                    state_d = (op_q == eepc_pkg::EEPC_OP_LAUNCH)
                            ? EEPC_S_LAUNCH1 : EEPC_S_MAP;
                end
            end
            EEPC_S_MAP: begin
                bus.instr     = 1'b1;
                bus.ctl_we    = 1'b1;
                bus.ctl_wdata = eepc_pkg::CMD_MAP;
                state_d       = EEPC_S_ACCESS;
            end
            EEPC_S_ACCESS: begin
                bus.instr  = 1'b1;
                bus.xd_req = 1'b1;
                bus.xd_we  = (op_q == eepc_pkg::EEPC_OP_LOAD);
                state_d    = bus.xd_we ? EEPC_S_UNMAP : EEPC_S_WAIT;
            end
            EEPC_S_WAIT: begin
                if (bus.xd_rvalid) begin
                    rd_d    = bus.xd_rdata;
                    rdv_d   = 1'b1;
                    state_d = EEPC_S_UNMAP;
                end
            end
            EEPC_S_UNMAP: begin
                bus.instr     = 1'b1;
                bus.ctl_we    = 1'b1;
                bus.ctl_wdata = eepc_pkg::CMD_UNMAP;
                gie_d         = saved_q;
                state_d       = EEPC_S_IDLE;
            end
            EEPC_S_LAUNCH1: begin
                bus.instr     = 1'b1;
                bus.ctl_we    = 1'b1;
                bus.ctl_wdata = eepc_pkg::CMD_LAUNCH1;
                state_d       = EEPC_S_LAUNCH2;
            end
            EEPC_S_LAUNCH2: begin
                // Issued the very next cycle so nothing sits between
                bus.instr     = 1'b1;
                bus.ctl_we    = 1'b1;
                bus.ctl_wdata = eepc_pkg::CMD_LAUNCH2;
                gie_d         = saved_q;
                state_d       = EEPC_S_IDLE;
            end
            default: begin
                state_d = EEPC_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_q <= EEPC_S_IDLE;
            op_q    <= 2'b00;
            addr_q  <= 16'h0000;
            data_q  <= 8'h00;
            rd_q    <= 8'h00;
            rdv_q   <= 1'b0;
            gie_q   <= 1'b0;
            saved_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q    <= op_d;
            addr_q  <= addr_d;
            data_q  <= data_d;
            rd_q    <= rd_d;
            rdv_q   <= rdv_d;
            gie_q   <= gie_d;
            saved_q <= saved_d;
        end
    end

    assign bus.xd_addr               = addr_q;
    assign bus.xd_wdata              = data_q;
    assign o_cmd_ready               = (state_q == EEPC_S_IDLE);
    assign o_rd_data                 = rd_q;
    assign o_rd_valid                = rdv_q;
    assign o_global_interrupt_enable = gie_q;

endmodule
`default_nettype wire

/* File: design/eepc_device.sv */
`timescale 1ns/1ns
`default_nettype none
module eepc_device #(
    parameter int unsigned PROG_CYCLES = eepc_pkg::PROG_CYCLES
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    eepc_if.device           bus,
    output logic             o_xram_req,
    output logic             o_xram_we,
    output logic [15:0]      o_xram_addr,
    output logic [7:0]       o_xram_wdata,
    input  wire logic [7:0]  i_xram_rdata
);

    localparam int unsigned PW = eepc_pkg::PAGE_W;
    localparam int unsigned CW = eepc_pkg::COL_W;
    localparam int unsigned NB = eepc_pkg::PAGE_BYTES;
    localparam int unsigned NE = eepc_pkg::EE_BYTES;
    localparam int unsigned ADDRW = eepc_pkg::ADDR_W;
    localparam logic [15:0] LOAD_CNT = 16'(PROG_CYCLES - 1);

    // Control state
    logic          map_q,   map_d;
    logic          armed_q, armed_d;
    logic          busy_q,  busy_d;
    logic [15:0]   cnt_q,   cnt_d;
    logic [PW-1:0] page_q,  page_d;
    logic          prog_done;

    // Column latches and array
    logic [7:0]    lat_q  [NB];
    logic [7:0]    lat_d  [NB];
    logic [NB-1:0] mark_q, mark_d;
    logic [7:0]    mem_q  [NE];
    logic [7:0]    mem_d  [NE];

    // Read path and XRAM stage
    logic [7:0]    rdata_q, rdata_d;
    logic          rvalid_q, rvalid_d;
    logic          pend_q, pend_d;
    logic          xreq_q, xreq_d;
    logic          xwe_q, xwe_d;
    logic [15:0]   xaddr_q, xaddr_d;
    logic [7:0]    xwdata_q, xwdata_d;

    logic          ee_sel;
    logic          latch_wr;
    logic          launch;
    logic [PW-1:0] wr_page;
    logic [CW-1:0] wr_col;

    always_comb begin
        ee_sel   = map_q && (bus.xd_addr >= eepc_pkg::EE_BASE)
                   && (bus.xd_addr <= eepc_pkg::EE_LAST);
        latch_wr = bus.xd_req && bus.xd_we && ee_sel && !busy_q;
        wr_page  = bus.xd_addr[CW +: PW];
        wr_col   = bus.xd_addr[CW-1:0];
        launch   = bus.ctl_we && armed_q && !busy_q
                   && (bus.ctl_wdata[eepc_pkg::CTL_CMD_LSB +: 4]
                       == eepc_pkg::LAUNCH_SECOND);
    end

    always_comb begin
        map_d     = map_q;
        armed_d   = armed_q;
        busy_d    = busy_q;
        cnt_d     = cnt_q;
        prog_done = 1'b0;
        if (bus.ctl_we) begin
            // Busy bit of the written value is dropped on purpose
            map_d = bus.ctl_wdata[eepc_pkg::CTL_MAP_BIT];
        end
        if (bus.instr) begin
            armed_d = 1'b0;
        end
        if (bus.ctl_we && !busy_q
            && bus.ctl_wdata[eepc_pkg::CTL_CMD_LSB +: 4]
               == eepc_pkg::LAUNCH_FIRST) begin
            armed_d = 1'b1;
        end
        if (launch) begin
            busy_d = 1'b1;
            cnt_d  = LOAD_CNT;
        end else if (busy_q) begin
            if (cnt_q == 16'h0000) begin
                busy_d    = 1'b0;
                prog_done = 1'b1;
            end else begin
                cnt_d = cnt_q - 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            map_q   <= 1'b0;
            armed_q <= 1'b0;
            busy_q  <= 1'b0;
            cnt_q   <= 16'h0000;
        end else begin
            map_q   <= map_d;
            armed_q <= armed_d;
            busy_q  <= busy_d;
            cnt_q   <= cnt_d;
        end
    end

    always_comb begin
        lat_d  = lat_q;
        mark_d = mark_q;
        page_d = page_q;
        if (prog_done) begin
            mark_d = '0;
        end
        if (latch_wr) begin
            if (wr_page != page_q) begin
                mark_d = '0;
            end
            page_d         = wr_page;
            lat_d[wr_col]  = bus.xd_wdata;
            mark_d[wr_col] = 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            mark_q <= '0;
            page_q <= '0;
        end else begin
            mark_q <= mark_d;
            page_q <= page_d;
        end
    end

    // Latch data needs no reset: unmarked bytes are never programmed
    always_ff @(posedge i_clock) begin
        lat_q <= lat_d;
    end

    always_comb begin
        mem_d = mem_q;
        if (prog_done) begin
            for (int c = 0; c < NB; c++) begin
                if (mark_q[c]) begin
                    mem_d[{page_q, CW'(c)}] = lat_q[c];
                end
            end
        end
    end

    // Array contents survive reset, as a nonvolatile store should
    always_ff @(posedge i_clock) begin
        mem_q <= mem_d;
    end

    always_comb begin
        rdata_d  = rdata_q;
        rvalid_d = 1'b0;
        pend_d   = 1'b0;
        xreq_d   = 1'b0;
        xwe_d    = 1'b0;
        xaddr_d  = xaddr_q;
        xwdata_d = xwdata_q;
        if (bus.xd_req && ee_sel) begin
            if (!bus.xd_we) begin
                // A read during programming sees blank data
                rdata_d  = busy_q ? eepc_pkg::BLANK_BYTE
                         : mem_q[bus.xd_addr[ADDRW-1:0]];
                rvalid_d = 1'b1;
            end
        end else if (bus.xd_req) begin
            xreq_d   = 1'b1;
            xwe_d    = bus.xd_we;
            xaddr_d  = bus.xd_addr;
            xwdata_d = bus.xd_wdata;
        end
        if (xreq_q && !xwe_q) begin
            pend_d = 1'b1;
        end
        if (pend_q) begin
            rdata_d  = i_xram_rdata;
            rvalid_d = 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
            pend_q   <= 1'b0;
            xreq_q   <= 1'b0;
            xwe_q    <= 1'b0;
            xaddr_q  <= 16'h0000;
            xwdata_q <= 8'h00;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
            pend_q   <= pend_d;
            xreq_q   <= xreq_d;
            xwe_q    <= xwe_d;
            xaddr_q  <= xaddr_d;
            xwdata_q <= xwdata_d;
        end
    end

    always_comb begin
        bus.ctl_rdata = 8'h00;
        bus.ctl_rdata[eepc_pkg::CTL_MAP_BIT]  = map_q;
        bus.ctl_rdata[eepc_pkg::CTL_BUSY_BIT] = busy_q;
    end

    assign bus.xd_rdata  = rdata_q;
    assign bus.xd_rvalid = rvalid_q;
    assign o_xram_req    = xreq_q;
    assign o_xram_we     = xwe_q;
    assign o_xram_addr   = xaddr_q;
    assign o_xram_wdata  = xwdata_q;

endmodule
`default_nettype wire

/* File: design/eepc_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface eepc_if;
    logic        instr;
    logic        ctl_we;
    logic [7:0]  ctl_wdata;
    logic [7:0]  ctl_rdata;
    logic        xd_req;
    logic        xd_we;
    logic [15:0] xd_addr;
    logic [7:0]  xd_wdata;
    logic [7:0]  xd_rdata;
    logic        xd_rvalid;

    modport device (
        input  instr, ctl_we, ctl_wdata, xd_req, xd_we, xd_addr, xd_wdata,
        output ctl_rdata, xd_rdata, xd_rvalid
    );
    modport core (
        output instr, ctl_we, ctl_wdata, xd_req, xd_we, xd_addr, xd_wdata,
        input  ctl_rdata, xd_rdata, xd_rvalid
    );
endinterface
`default_nettype wire

/* File: design/eepc_pkg.sv */
package eepc_pkg;

    localparam int unsigned ADDR_W      = 11;
    localparam int unsigned PAGE_W      = 4;
    localparam int unsigned COL_W       = 7;
    localparam int unsigned PAGE_BYTES  = 128;
    localparam int unsigned EE_BYTES    = 2048;
    localparam int unsigned PROG_CYCLES = 200;

    localparam logic [15:0] EE_BASE     = 16'h0000;
    localparam logic [15:0] EE_LAST     = 16'h07FF;

    localparam int unsigned CTL_BUSY_BIT = 0;
    localparam int unsigned CTL_MAP_BIT  = 1;
    localparam int unsigned CTL_CMD_LSB  = 4;
    localparam logic [7:0]  CTL_RESET    = 8'h00;

    localparam logic [3:0]  LAUNCH_FIRST  = 4'h5;
    localparam logic [3:0]  LAUNCH_SECOND = 4'hA;
    localparam logic [7:0]  CMD_MAP       = 8'h02;
    localparam logic [7:0]  CMD_UNMAP     = 8'h00;
    localparam logic [7:0]  CMD_LAUNCH1   = 8'h50;
    localparam logic [7:0]  CMD_LAUNCH2   = 8'hA0;

    localparam logic [7:0]  BLANK_BYTE    = 8'hFF;

    typedef enum logic [1:0] {
        EEPC_OP_READ   = 2'b00,
        EEPC_OP_LOAD   = 2'b01,
        EEPC_OP_LAUNCH = 2'b10
    } eepc_op_type;

endpackage

/* File: sim/eepc_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module eepc_checker #(
    parameter int unsigned PROG_CYCLES = eepc_pkg::PROG_CYCLES
) (
    input wire logic        i_clock,
    input wire logic        i_rst,
    input wire logic        instr,
    input wire logic        ctl_we,
    input wire logic [7:0]  ctl_wdata,
    input wire logic [7:0]  ctl_rdata,
    input wire logic        xd_req,
    input wire logic        xd_we,
    input wire logic [15:0] xd_addr,
    input wire logic [7:0]  xd_rdata,
    input wire logic        xd_rvalid
);
    logic        arm_q;
    logic        arm_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic        go;
    logic        ee;
    logic        rd;

    // Launch qualifies only when the 5x write was the previous instruction
    assign go = ctl_we && ctl_wdata[7:4] == eepc_pkg::LAUNCH_SECOND
                && arm_q && !ctl_rdata[0];
    assign ee = ctl_rdata[1] && xd_addr <= eepc_pkg::EE_LAST;
    assign rd = xd_req && !xd_we;

    always_comb begin
        arm_d = arm_q;
        if (instr) begin
            arm_d = ctl_we && !ctl_rdata[0]
                    && ctl_wdata[7:4] == eepc_pkg::LAUNCH_FIRST;
        end
        cnt_d = ctl_rdata[0] ? cnt_q + 16'h0001 : 16'h0000;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            arm_q <= 1'b0;
            cnt_q <= 16'h0000;
        end else begin
            arm_q <= arm_d;
            cnt_q <= cnt_d;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    property p_launch;
        go |=> ctl_rdata[0];
    endproperty
    a_launch: assert property (p_launch)
        else $error("busy did not rise after launch");
    property p_abort;
        $rose(ctl_rdata[0]) |-> $past(go);
    endproperty
    a_abort: assert property (p_abort)
        else $error("busy rose without back to back launch");
    property p_busy_len;
        $fell(ctl_rdata[0]) |-> cnt_q == PROG_CYCLES;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy length wrong");
    property p_busy_max;
        ctl_rdata[0] |-> cnt_q < PROG_CYCLES;
    endproperty
    a_busy_max: assert property (p_busy_max)
        else $error("busy held too long");
    property p_busy_rd;
        rd && ee && ctl_rdata[0] |=> xd_rvalid
            && xd_rdata == eepc_pkg::BLANK_BYTE;
    endproperty
    a_busy_rd: assert property (p_busy_rd)
        else $error("read while busy not blanked");
    property p_ee_rd;
        rd && ee && !ctl_rdata[0] |=> xd_rvalid;
    endproperty
    a_ee_rd: assert property (p_ee_rd)
        else $error("eeprom read answer late");
    property p_xram;
        rd && !ee |=> !xd_rvalid ##1 !xd_rvalid ##1 xd_rvalid;
    endproperty
    a_xram: assert property (p_xram)
        else $error("xram read timing wrong");
    property p_map;
        ctl_we |=> ctl_rdata[1] == $past(ctl_wdata[1]);
    endproperty
    a_map: assert property (p_map)
        else $error("map bit not taken");
    property p_rsvd;
        ctl_rdata[7:2] == 6'h00;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved control bits set");
    property p_pulse;
        xd_rvalid |=> !xd_rvalid;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("read valid longer than one cycle");

    c_launch: cover property (go);
    c_xram: cover property (rd && !ee);
    c_ee: cover property (rd && ee);
endmodule
`default_nettype wire

/* File: sim/test_eeprom_page_program_control.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        n_tests++; \
        if ((g) !== (e)) begin \
            errors++; \
            $display("MISMATCH %s exp %h got %h", nm, e, g); \
        end \
    end
module test_eeprom_page_program_control;
    localparam int unsigned PC = 12;
    logic        i_clock;
    logic        i_rst;
    logic        i_cmd_valid;
    logic [1:0]  i_cmd_op;
    logic [15:0] i_cmd_addr;
    logic [7:0]  i_cmd_data;
    logic        i_irq_enable;
    logic        o_cmd_ready;
    logic [7:0]  o_rd_data;
    logic        o_rd_valid;
    logic        gie;
    logic        x_req;
    logic        x_we;
    logic [15:0] x_addr;
    logic [7:0]  x_wdata;
    logic [7:0]  x_rdata;
    logic [7:0]  xram [256];
    logic [7:0]  rd_q [$];
    logic [7:0]  d;
    int          errors;
    int          n_tests;
    int          cycles;
    int          seed;
    int          lpg;
    int          bcnt;
    int          mem [int];
    int          ldat [128];
    bit          lmk [128];

    eepc_if bus ();
    eepc_if bus2 ();
    eepc_core eepc_core_i (.i_clock(i_clock), .i_rst(i_rst),
        .bus(bus.core), .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op),
        .i_cmd_addr(i_cmd_addr), .i_cmd_data(i_cmd_data),
        .i_irq_enable(i_irq_enable), .o_cmd_ready(o_cmd_ready),
        .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
        .o_global_interrupt_enable(gie));
    eepc_device #(.PROG_CYCLES(PC)) eepc_device_i (.i_clock(i_clock),
        .i_rst(i_rst), .bus(bus.device), .o_xram_req(x_req),
        .o_xram_we(x_we), .o_xram_addr(x_addr), .o_xram_wdata(x_wdata),
        .i_xram_rdata(x_rdata));
    // Second device faces the bench directly so the core's rules can break
    eepc_device #(.PROG_CYCLES(PC)) eepc_device_i2 (.i_clock(i_clock),
        .i_rst(i_rst), .bus(bus2.device), .o_xram_req(), .o_xram_we(),
        .o_xram_addr(), .o_xram_wdata(), .i_xram_rdata(8'h00));
    eepc_checker #(.PROG_CYCLES(PC)) eepc_checker_i (.i_clock(i_clock),
        .i_rst(i_rst), .instr(bus.instr), .ctl_we(bus.ctl_we),
        .ctl_wdata(bus.ctl_wdata), .ctl_rdata(bus.ctl_rdata),
        .xd_req(bus.xd_req), .xd_we(bus.xd_we), .xd_addr(bus.xd_addr),
        .xd_rdata(bus.xd_rdata), .xd_rvalid(bus.xd_rvalid));

    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end

    always @(posedge i_clock) begin
        if (x_req && x_we) xram[x_addr[7:0]] <= x_wdata;
        if (x_req) x_rdata <= xram[x_addr[7:0]];
        if (o_rd_valid) rd_q.push_back(o_rd_data);
        if (bus2.ctl_rdata[0]) bcnt++;
        cycles++;
        if (cycles > 20000) begin
            errors++;
            final_report();
        end
    end

    task automatic cmd(input logic [1:0] op, input logic [15:0] a,
                       input logic [7:0] v);
        int n;
        n = 0;
        @(negedge i_clock);
        while (o_cmd_ready !== 1'b1 && n < 500) begin
            @(negedge i_clock);
            n++;
        end
        @(posedge i_clock);
        i_cmd_valid <= 1'b1;
        i_cmd_op <= op;
        i_cmd_addr <= a;
        i_cmd_data <= v;
        @(posedge i_clock);
        i_cmd_valid <= 1'b0;
    endtask

    task automatic load(input logic [15:0] a, input logic [7:0] v);
        cmd(eepc_pkg::EEPC_OP_LOAD, a, v);
        if (a <= 16'h07FF) begin
            if (int'(a[10:7]) != lpg) lmk = '{default: 1'b0};
            lpg = int'(a[10:7]);
            lmk[a[6:0]] = 1'b1;
            ldat[a[6:0]] = int'(v);
        end
    endtask

    task automatic launch();
        cmd(eepc_pkg::EEPC_OP_LAUNCH, 16'h0000, 8'h00);
        for (int i = 0; i < 128; i++) begin
            if (lmk[i]) mem[lpg * 128 + i] = ldat[i];
        end
        lmk = '{default: 1'b0};
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        int n;
        n = 0;
        rd_q.delete();
        cmd(eepc_pkg::EEPC_OP_READ, a, 8'h00);
        @(negedge i_clock);
        `CHK("gie_off", 1'b0, gie)
        while (rd_q.size() == 0 && n < 50) begin
            @(negedge i_clock);
            n++;
        end
        `CHK("rd_data", e, rd_q.size() ? rd_q.pop_front() : 8'hxx)
    endtask

    task automatic wr2(input logic [7:0] v);
        bus2.instr <= 1'b1;
        bus2.ctl_we <= 1'b1;
        bus2.xd_req <= 1'b0;
        bus2.ctl_wdata <= v;
        @(posedge i_clock);
    endtask

    task automatic idle2();
        bus2.instr <= 1'b0;
        bus2.ctl_we <= 1'b0;
        bus2.xd_req <= 1'b0;
        @(posedge i_clock);
        @(negedge i_clock);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        seed = 32'h86ed;
        {errors, n_tests, cycles, lpg, bcnt} = '0;
        lmk = '{default: 1'b0};
        {i_rst, i_irq_enable} = 2'b11;
        {i_cmd_valid, i_cmd_op, i_cmd_addr, i_cmd_data, x_rdata} = '0;
        {bus2.instr, bus2.ctl_we, bus2.ctl_wdata, bus2.xd_req} = '0;
        {bus2.xd_we, bus2.xd_addr, bus2.xd_wdata} = '0;
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        load(16'h0104, 8'h3C);
        launch();
        load(16'h0104, 8'hC3);
        load(16'h0300, 8'($random(seed)));
        load(16'h037F, 8'($random(seed)));
        launch();
        rd(16'h0104, 8'h3C);
        rd(16'h0300, 8'(mem[16'h0300]));
        rd(16'h037F, 8'(mem[16'h037F]));
        load(16'h0305, 8'($random(seed)));
        launch();
        rd(16'h0300, 8'(mem[16'h0300]));
        rd(16'h0305, 8'(mem[16'h0305]));
        for (int i = 16'h07FC; i <= 16'h07FF; i++) load(16'(i), 8'(i));
        launch();
        for (int i = 16'h07FC; i <= 16'h07FF; i++) rd(16'(i), 8'(i));
        d = 8'($random(seed));
        load(16'h0800, d);
        rd(16'h0800, d);
        `CHK("gie", 1'b1, gie)
        @(posedge i_clock);
        wr2(eepc_pkg::CMD_LAUNCH1);
        wr2(eepc_pkg::CMD_MAP);
        wr2(eepc_pkg::CMD_LAUNCH2);
        idle2();
        `CHK("busy_abort", 1'b0, bus2.ctl_rdata[0])
        @(posedge i_clock);
        wr2(8'h01);
        idle2();
        `CHK("ctl_rdata", 8'h00, bus2.ctl_rdata)
        @(posedge i_clock);
        wr2(8'h52);
        idle2();
        @(posedge i_clock);
        wr2(8'hA2);
        // The read must be taken while busy is up, three cycles after the launch
        idle2();
        @(posedge i_clock);
        bus2.instr <= 1'b1;
        bus2.xd_req <= 1'b1;
        bus2.xd_addr <= 16'h0300;
        @(posedge i_clock);
        idle2();
        `CHK("busy_rd", 8'hFF, bus2.xd_rdata)
        @(posedge i_clock);
        wr2(eepc_pkg::CMD_LAUNCH1);
        wr2(eepc_pkg::CMD_LAUNCH2);
        wr2(eepc_pkg::CMD_UNMAP);
        idle2();
        `CHK("busy_hold", 1'b1, bus2.ctl_rdata[0])
        repeat (3 * PC) @(posedge i_clock);
        `CHK("busy_cycles", PC, bcnt)
        final_report();
    end
endmodule
`default_nettype wire
